// File: inc/dcp_pkg.sv
package dcp_pkg;
  typedef logic [16:0] dcp_addr_t;
  typedef logic [1:0]  dcp_grp_t;
  typedef logic [3:0]  dcp_radr_t;
  typedef logic [31:0] dcp_word_t;
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_WAIT  = 4'b0010,
    S_ALERT = 4'b0100,
    S_POST  = 4'b1000
  } dcp_state_e;
endpackage

// File: inc/dcp_regs.svh
`ifndef DCP_REGS_SVH
`define DCP_REGS_SVH
// Register offsets of the software port
`define DCP_REG_CMD        4'h0
`define DCP_REG_MR5        4'h4
`define DCP_REG_STAT       4'h8
`define DCP_REG_CTRL       4'hC
// Command register fields
`define DCP_CMD_CKE        22
`define DCP_CMD_ACT        21
`define DCP_CMD_BG_LSB     19
`define DCP_CMD_BA_LSB     17
// Mode register 5 fields
`define DCP_MR5_PL_LSB     0
`define DCP_MR5_ERR_BIT    4
`define DCP_MR5_PERS_BIT   9
`define DCP_MR5_BG         2'h1
`define DCP_MR5_BA         2'h1
// Control register fields
`define DCP_CTRL_CLR       0
`define DCP_CTRL_CKSTOP    1
`define DCP_CTRL_FLAGCLR   2
`define DCP_CTRL_AUTOCLR   3
// Timing, clock is 250 MHz
`define DCP_CLK_MHZ        250
`define DCP_T_MOD_NCK      24
`define DCP_ALERT_ON_NS    10
`define DCP_ALERT_ON_CYC   ((`DCP_ALERT_ON_NS * `DCP_CLK_MHZ + 999) / 1000)
`define DCP_REL_DES_NS     3
`define DCP_REL_DES_CYC    (1 + (`DCP_REL_DES_NS * `DCP_CLK_MHZ + 999) / 1000)
`define DCP_T_RFC_NS       350
`define DCP_T_RFC_CYC      ((`DCP_T_RFC_NS * `DCP_CLK_MHZ + 999) / 1000)
`define DCP_XS_WIN_CYC     128
`define DCP_EXTRA_REF      2
`endif

// File: rtl/dcp_ctrl.sv
`timescale 1ns/1ps
`include "dcp_regs.svh"
// What the document asks of this block and of the device
// RULE1: Issue extra refreshes after every alert
// RULE2: Device reads status after alert window
// RULE3: Device keeps first error log
// RULE4: Device latency write-only, status read/write, log read-only
// RULE5: Only ever write zero to status
// RULE6: Device may block writing one
// RULE7: Device persistent mode resumes checking
// RULE8: Log undefined after several errors
// RULE9: Device times alert pulse itself
// RULE10: Send only deselects after alert
// RULE11: Latency codes 0,4,5,6,8 clocks
// RULE12: Device status bit shows pending error
// RULE13: Device stops checking until status cleared
// RULE14: Device recovers within alert pulse
// RULE15: Commands before error are uncertain
// RULE16: Change latency only through disabled
// RULE17: Device adds latency to read/write
// RULE18: Device turns bad entry into power-down
// RULE19: Keep clock until error detectable
// RULE20: Deselects only during recovery
// RULE21: Only mode writes or ZQ after exit error; code filters queued commands only, owed refreshes still go out
// RULE22: Mode command spacing stretched by latency
// RULE23: Even parity over covered inputs
// RULE24: Device drives alert low on error
// RULE25: Parity covers command, address, bank bits
module dcp_ctrl #(
  parameter int EXTRA_REF = `DCP_EXTRA_REF
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire dcp_pkg::dcp_radr_t i_addr,
  input  wire dcp_pkg::dcp_word_t i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output      dcp_pkg::dcp_word_t o_rdata,
  input  wire logic              i_alert_n,
  output      logic              o_cs_n,
  output      logic              o_act_n,
  output      dcp_pkg::dcp_addr_t o_a,
  output      dcp_pkg::dcp_grp_t  o_bg,
  output      dcp_pkg::dcp_grp_t  o_ba,
  output      logic              o_par,
  output      logic              o_cke,
  output      logic              o_ck_en
);
  import dcp_pkg::*;

  dcp_state_e st_r;
  logic [22:0] cmd_r;
  logic        cmd_pend_r, mr_pend_r, clr_pend_r;
  logic [2:0]  tgt_pl_r, cur_pl_r;
  logic        tgt_pers_r, cur_pers_r;
  logic        ckstop_r, autoclr_r;
  logic [7:0]  wait_r, guard_r, xs_r;
  logic [3:0]  ref_owed_r;
  logic [1:0]  err_cnt_r;
  logic        uncert_r, refused_r, restrict_r, sr_r;

  // Latency decode in clocks; unused codes treated as disabled
  function automatic logic [3:0] pl_cyc(input logic [2:0] code);
    unique case (code) // RULE11
      3'h1:    pl_cyc = 4'h4;
      3'h2:    pl_cyc = 4'h5;
      3'h3:    pl_cyc = 4'h6;
      3'h4:    pl_cyc = 4'h8;
      default: pl_cyc = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Issue decisions
  logic       idle_go, do_mr, do_clr, do_cmd, do_ref, mr_step0, cmd_ok;
  logic       alert_fell, cmd_sre, cmd_srx;
  logic [2:0] send_pl;
  logic [3:0] pl_max;
  logic       alert_d_r;

  assign idle_go  = (st_r == S_IDLE) && i_alert_n;
  assign do_mr    = idle_go && mr_pend_r;
  assign do_clr   = idle_go && !mr_pend_r && clr_pend_r;
  assign do_cmd   = idle_go && !mr_pend_r && !clr_pend_r && cmd_pend_r;
  assign do_ref   = idle_go && !mr_pend_r && !clr_pend_r && !cmd_pend_r && (ref_owed_r != 4'h0);
  // Never hop between two non-zero latencies
  assign mr_step0 = (cur_pl_r != 3'h0) && (tgt_pl_r != 3'h0) && (cur_pl_r != tgt_pl_r); // RULE16
  assign send_pl  = mr_step0 ? 3'h0 : tgt_pl_r; // RULE16
  assign pl_max   = (pl_cyc(cur_pl_r) > pl_cyc(send_pl)) ? pl_cyc(cur_pl_r) : pl_cyc(send_pl);
  // After an exit error only mode writes and ZQ may pass from the command register
  assign cmd_ok   = !restrict_r || (cmd_r[`DCP_CMD_ACT] &&
                    ((cmd_r[16:14] == 3'h0) || (cmd_r[16:14] == 3'h6))); // RULE21
  assign cmd_sre  = cmd_r[`DCP_CMD_ACT] && (cmd_r[16:14] == 3'h1) && !cmd_r[`DCP_CMD_CKE] && o_cke;
  assign cmd_srx  = sr_r && cmd_r[`DCP_CMD_CKE];
  assign alert_fell = alert_d_r && !i_alert_n; // RULE24

  ////////////////////////////////////////////////////////////////////////////
  // Software port
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmd_r      <= 23'h400000;
      cmd_pend_r <= 1'b0;
      mr_pend_r  <= 1'b0;
      clr_pend_r <= 1'b0;
      tgt_pl_r   <= 3'h0;
      tgt_pers_r <= 1'b0;
      ckstop_r   <= 1'b0;
      autoclr_r  <= 1'b0;
      o_rdata    <= 32'h0;
    end else begin
      if (do_cmd) cmd_pend_r <= 1'b0;
      if (do_mr && !mr_step0) mr_pend_r <= 1'b0;
      if (do_clr) clr_pend_r <= 1'b0;
      // Persistent mode off: checking only resumes once status is cleared
      if (st_r == S_POST && autoclr_r && !cur_pers_r) clr_pend_r <= 1'b1;
      if (i_wr) begin
        unique case (i_addr)
          `DCP_REG_CMD: if (!cmd_pend_r) begin
            cmd_r      <= i_wdata[22:0];
            cmd_pend_r <= 1'b1;
          end
          `DCP_REG_MR5: begin
            tgt_pl_r   <= i_wdata[`DCP_MR5_PL_LSB +: 3];
            tgt_pers_r <= i_wdata[`DCP_MR5_PERS_BIT];
            mr_pend_r  <= 1'b1;
          end
          `DCP_REG_CTRL: begin
            if (i_wdata[`DCP_CTRL_CLR]) clr_pend_r <= 1'b1;
            ckstop_r  <= i_wdata[`DCP_CTRL_CKSTOP];
            autoclr_r <= i_wdata[`DCP_CTRL_AUTOCLR];
          end
          default: ;
        endcase
      end
      o_rdata <= 32'h0;
      if (i_rd) begin
        unique case (i_addr)
          `DCP_REG_CMD:  o_rdata <= {9'h0, cmd_r};
          `DCP_REG_MR5:  o_rdata <= {22'h0, cur_pers_r, 6'h0, cur_pl_r};
          // Log is only meaningful after exactly one error
          `DCP_REG_STAT: o_rdata <= {16'h0, ref_owed_r, err_cnt_r, (err_cnt_r == 2'h1), // RULE8
                                     uncert_r, refused_r, restrict_r, sr_r, st_r, cmd_pend_r};
          `DCP_REG_CTRL: o_rdata <= {28'h0, autoclr_r, 1'b0, ckstop_r, 1'b0};
          default:       o_rdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and command pins
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r       <= S_IDLE;
      wait_r     <= 8'h0;
      cur_pl_r   <= 3'h0;
      cur_pers_r <= 1'b0;
      o_cs_n     <= 1'b1;
      o_act_n    <= 1'b1;
      o_a        <= '0;
      o_bg       <= 2'h0;
      o_ba       <= 2'h0;
      o_par      <= 1'b0;
      o_cke      <= 1'b1;
    end else begin
      o_cs_n <= 1'b1; // RULE10 RULE20
      unique case (st_r)
        S_IDLE: begin
          if (!i_alert_n) begin
            st_r <= S_ALERT; // RULE10
          end else if (do_mr || do_clr) begin
            o_cs_n  <= 1'b0;
            o_act_n <= 1'b1;
            o_bg    <= `DCP_MR5_BG;
            o_ba    <= `DCP_MR5_BA;
            o_a     <= '0;
            o_a[`DCP_MR5_PL_LSB +: 3] <= do_mr ? send_pl : cur_pl_r;
            o_a[`DCP_MR5_PERS_BIT]    <= do_mr ? tgt_pers_r : cur_pers_r;
            o_a[`DCP_MR5_ERR_BIT]     <= 1'b0; // RULE5 RULE6
            o_par   <= ^{1'b1, do_mr ? send_pl : cur_pl_r,
                         do_mr ? tgt_pers_r : cur_pers_r, `DCP_MR5_BG, `DCP_MR5_BA}; // RULE23
            if (do_mr) begin
              cur_pl_r   <= send_pl;
              cur_pers_r <= tgt_pers_r;
            end
            // Entering or leaving parity stretches the spacing by the latency
            wait_r <= 8'(`DCP_T_MOD_NCK - 1) + 8'(pl_max); // RULE22
            st_r   <= S_WAIT;
          end else if (do_cmd) begin
            if (cmd_ok) begin
              o_cs_n  <= 1'b0;
              o_act_n <= cmd_r[`DCP_CMD_ACT];
              o_bg    <= cmd_r[`DCP_CMD_BG_LSB +: 2];
              o_ba    <= cmd_r[`DCP_CMD_BA_LSB +: 2];
              o_a     <= cmd_r[16:0];
              o_par   <= ^cmd_r[21:0]; // RULE23 RULE25
            end
            o_cke <= cmd_r[`DCP_CMD_CKE];
          end else if (do_ref) begin
            o_cs_n  <= 1'b0;
            o_act_n <= 1'b1;
            o_a     <= {3'h1, 14'h0};
            o_bg    <= 2'h0;
            o_ba    <= 2'h0;
            o_par   <= 1'b0; // RULE23
            wait_r  <= 8'(`DCP_T_RFC_CYC - 1);
            st_r    <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (!i_alert_n) st_r <= S_ALERT; // RULE10
          else if (wait_r == 8'h0) st_r <= S_IDLE;
          else wait_r <= wait_r - 8'h1;
        end
        S_ALERT: begin
          // Deselects keep going past the release of the alert
          if (i_alert_n) begin
            wait_r <= 8'(`DCP_REL_DES_CYC - 1); // RULE20
            st_r   <= S_POST;
          end
        end
        S_POST: begin
          if (!i_alert_n) st_r <= S_ALERT;
          else if (wait_r == 8'h0) st_r <= S_IDLE;
          else wait_r <= wait_r - 8'h1;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error bookkeeping, refresh debt, self-refresh tracking
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      alert_d_r  <= 1'b1;
      err_cnt_r  <= 2'h0;
      uncert_r   <= 1'b0;
      refused_r  <= 1'b0;
      restrict_r <= 1'b0;
      ref_owed_r <= 4'h0;
      sr_r       <= 1'b0;
      xs_r       <= 8'h0;
      guard_r    <= 8'h0;
      o_ck_en    <= 1'b1;
    end else begin
      alert_d_r <= i_alert_n;
      // Flag clear first so that a same-cycle event still sets
      if (i_wr && i_addr == `DCP_REG_CTRL && i_wdata[`DCP_CTRL_FLAGCLR]) begin
        uncert_r  <= 1'b0;
        refused_r <= 1'b0;
      end
      if (do_clr) begin
        err_cnt_r  <= 2'h0;
        restrict_r <= 1'b0;
      end
      if (alert_fell) begin
        if (err_cnt_r != 2'h3) err_cnt_r <= err_cnt_r + 2'h1; // RULE8
        uncert_r <= 1'b1; // RULE15
        if (xs_r != 8'h0) restrict_r <= 1'b1; // RULE21
      end
      if (do_cmd && !cmd_ok) refused_r <= 1'b1; // RULE21
      // A refresh may have been lost in the alert window
      if (st_r == S_ALERT && i_alert_n) begin
        ref_owed_r <= ref_owed_r + 4'(EXTRA_REF); // RULE1
      end else if (do_ref) begin
        ref_owed_r <= ref_owed_r - 4'h1;
      end
      if (xs_r != 8'h0) xs_r <= xs_r - 8'h1;
      if (guard_r != 8'h0) guard_r <= guard_r - 8'h1;
      if (do_cmd && cmd_ok && cmd_sre) begin
        sr_r    <= 1'b1;
        guard_r <= 8'(`DCP_ALERT_ON_CYC) + 8'(pl_cyc(cur_pl_r)); // RULE19
      end else if (do_cmd && cmd_srx) begin
        sr_r <= 1'b0;
        xs_r <= 8'(`DCP_XS_WIN_CYC);
      end
      // Clock stops only once a parity error on entry would have shown
      o_ck_en <= !(ckstop_r && sr_r && guard_r == 8'h0 && i_alert_n
                   && st_r == S_IDLE); // RULE19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] gap_r, need_r;
  logic [2:0] last_pl_r;
  logic       mr_seen_r;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_r     <= 8'hFF;
      need_r    <= 8'h0;
      last_pl_r <= 3'h0;
      mr_seen_r <= 1'b0;
    end else if (!o_cs_n && o_act_n && o_a[16:14] == 3'h0 && o_ba == `DCP_MR5_BA
                 && o_bg == `DCP_MR5_BG) begin
      gap_r     <= 8'h1;
      need_r    <= 8'(`DCP_T_MOD_NCK) + 8'(pl_cyc(last_pl_r) > pl_cyc(o_a[2:0]) ?
                   pl_cyc(last_pl_r) : pl_cyc(o_a[2:0]));
      last_pl_r <= o_a[2:0];
      mr_seen_r <= 1'b1;
    end else if (gap_r != 8'hFF) begin
      gap_r <= gap_r + 8'h1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence mr5_frame_s;
    !o_cs_n && o_act_n && o_a[16:14] == 3'h0 && o_bg == `DCP_MR5_BG && o_ba == `DCP_MR5_BA;
  endsequence
  sequence alert_release_s;
    st_r == S_ALERT && i_alert_n;
  endsequence

  alert_des_a: assert property (!i_alert_n |=> o_cs_n) // RULE10
    else $error("command issued while alert low");
  even_parity_a: assert property (!o_cs_n |-> !(^{o_par, o_act_n, o_a, o_bg, o_ba})) // RULE23
    else $error("odd parity on command frame");
  pl_step_a: assert property (mr5_frame_s and o_a[2:0] != 3'h0 |-> last_pl_r == 3'h0 // RULE16
    || last_pl_r == o_a[2:0]) else $error("latency changed between non-zero values");
  status_zero_a: assert property (mr5_frame_s |-> !o_a[`DCP_MR5_ERR_BIT]) // RULE5
    else $error("status bit written as one");
  mrs_gap_a: assert property (mr_seen_r && !o_cs_n |-> gap_r >= need_r) // RULE22
    else $error("mode command spacing too short");
  post_des_a: assert property (st_r == S_POST |-> o_cs_n ##1 o_cs_n) // RULE20
    else $error("command during alert recovery");
  extra_ref_a: assert property (alert_release_s |=> ref_owed_r == // RULE1
    4'($past(ref_owed_r) + EXTRA_REF)) else $error("refresh debt not raised");
  ck_hold_a: assert property ($fell(o_ck_en) |-> sr_r && $past(guard_r) == 8'h0) // RULE19
    else $error("clock stopped too early");
  restrict_a: assert property (restrict_r && !o_cs_n |-> o_act_n && // RULE21
    (o_a[16:14] == 3'h0 || o_a[16:14] == 3'h6)) else $error("illegal command after exit error");
endmodule

// File: sim/dcp_mem_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Memory side: parity check, alert pulse, parity mode register
module dcp_mem_model #(
  parameter int ON_CYC = 2,
  parameter int PW_CYC = 8
) (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_cs_n,
  input  wire logic               i_act_n,
  input  wire dcp_pkg::dcp_addr_t i_a,
  input  wire dcp_pkg::dcp_grp_t  i_bg,
  input  wire dcp_pkg::dcp_grp_t  i_ba,
  input  wire logic               i_par,
  input  wire logic               i_inject,
  output      logic               o_alert_n,
  output      logic               o_status
);
  import dcp_pkg::*;
  logic [2:0] pl_r;
  logic       pers_r;
  logic [7:0] cnt_r;
  dcp_addr_t  log_r;
  logic       bad;
  logic       chk;
  logic       mr5;
  // Inject lets a scenario corrupt one frame the controller sent clean
  assign bad = (^{i_act_n, i_a, i_bg, i_ba, i_par}) | i_inject;
  // No checking during the pulse, nor after it unless persistent
  assign chk = (pl_r != 3'h0) && (!o_status || pers_r) && (cnt_r == 8'h0);
  assign mr5 = i_act_n && (i_a[16:14] == 3'h0) && (i_bg == 2'h1) && (i_ba == 2'h1);
  assign o_alert_n = !((cnt_r != 8'h0) && (cnt_r <= 8'(PW_CYC)));
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pl_r     <= 3'h0;
      pers_r   <= 1'b0;
      cnt_r    <= 8'h0;
      log_r    <= '0;
      o_status <= 1'b0;
    end else begin
      if (cnt_r != 8'h0) begin
        cnt_r <= cnt_r - 8'h1;
      end
      if (!i_cs_n && bad && chk) begin
        o_status <= 1'b1;
        cnt_r    <= 8'(ON_CYC + PW_CYC);
        if (!o_status) begin
          log_r <= i_a;
        end
      end else if (!i_cs_n && mr5) begin
        pl_r   <= i_a[2:0];
        pers_r <= i_a[9];
        // Writing one is blocked, only a clear lands
        if (!i_a[4]) begin
          o_status <= 1'b0;
        end
      end
    end
  end
endmodule

// File: sim/ddr4_ca_parity_checker_test.sv
`timescale 1ns/1ps
`include "dcp_regs.svh"
module ddr4_ca_parity_checker_test;
  import dcp_pkg::*;
  logic      clk = 1'b0;
  logic      nrst = 1'b0;
  logic      wr = 1'b0;
  logic      rd = 1'b0;
  logic      inj = 1'b0;
  dcp_radr_t addr = '0;
  dcp_word_t wdata = '0;
  dcp_word_t rdata;
  dcp_word_t rv;
  logic      cs_n, act_n, par, cke, ck_en, alert_n, status;
  dcp_addr_t a;
  dcp_grp_t  bg, ba;
  int        n_fail = 0;
  int        compares = 0;
  int        gap;
  always #2 clk = ~clk;
  dcp_ctrl #(.EXTRA_REF(1)) dcp_ctrl_inst (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_alert_n(alert_n), .o_cs_n(cs_n),
    .o_act_n(act_n), .o_a(a), .o_bg(bg), .o_ba(ba), .o_par(par), .o_cke(cke), .o_ck_en(ck_en));
  dcp_mem_model dcp_mem_model_inst (.i_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_act_n(act_n),
    .i_a(a), .i_bg(bg), .i_ba(ba), .i_par(par), .i_inject(inj), .o_alert_n(alert_n),
    .o_status(status));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic wr_reg(input dcp_radr_t ad, input dcp_word_t d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input dcp_radr_t ad, output dcp_word_t d);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Data stand only in this cycle, so take them mid-cycle
    @(negedge clk);
    d = rdata;
  endtask
  // Bounded, so a lost frame cannot hang the run
  task automatic wait_frame(output int g);
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (cs_n !== 1'b0 && g < 600);
    check(g < 600, "frame missing");
    check((^{act_n, a, bg, ba, par}) === 1'b0, "odd parity");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check({cs_n, cke, ck_en, par} === 4'hE, "pins after reset");
    rd_reg(4'h2, rv);
    check(rv === 32'h0, "unmapped read");
    rd_reg(`DCP_REG_STAT, rv);
    check(rv[4:0] === 5'h02, "idle status");
  endtask
  task automatic t_cmd;
    wr_reg(`DCP_REG_CMD, {9'h0, 1'b1, 1'b0, 2'h2, 2'h3, 17'h1ABCD});
    wait_frame(gap);
    check({cke, act_n, bg, ba, a} === {1'b1, 1'b0, 2'h2, 2'h3, 17'h1ABCD}, "cmd fields");
  endtask
  task automatic t_latency;
    wr_reg(`DCP_REG_MR5, 32'h1);
    wait_frame(gap);
    check({act_n, a[16:14], bg, ba, a[4:0]} === {1'b1, 3'h0, 2'h1, 2'h1, 5'h01}, "mr5 pl4");
    wr_reg(`DCP_REG_MR5, 32'h2);
    wait_frame(gap);
    check(a[2:0] === 3'h0, "no disable step");
    wait_frame(gap);
    check(a[2:0] === 3'h2, "new latency");
    check(gap >= 29, "mode spacing short");
  endtask
  // Corrupted frame, then a command queued while the alert is low
  task automatic t_alert;
    inj <= 1'b1;
    wr_reg(`DCP_REG_CMD, {9'h0, 1'b1, 1'b0, 2'h1, 2'h2, 17'h00155});
    wait_frame(gap);
    @(posedge clk);
    inj <= 1'b0;
    repeat (4) @(negedge clk);
    check(alert_n === 1'b0, "alert missing");
    wr_reg(`DCP_REG_CMD, {9'h0, 1'b1, 1'b0, 2'h0, 2'h1, 17'h00AA0});
    for (int i = 0; i < 20 && alert_n === 1'b0; i++) begin
      @(negedge clk);
      check(cs_n === 1'b1, "frame during alert");
    end
    repeat (2) @(negedge clk);
    check(cs_n === 1'b1, "frame in release tail");
    wait_frame(gap);
    check({act_n, bg, ba, a} === {1'b0, 2'h0, 2'h1, 17'h00AA0}, "queued cmd");
    wait_frame(gap);
    check({act_n, a[16:14]} === 4'h9, "extra refresh");
    check(status === 1'b1, "status not set");
    rd_reg(`DCP_REG_STAT, rv);
    check(rv[11:10] === 2'h1, "error count");
    wr_reg(`DCP_REG_CTRL, 32'h1);
    wait_frame(gap);
    check({a[4], a[2:0]} === 4'h2, "status clear frame");
    @(negedge clk);
    check(status === 1'b0, "status not cleared");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(4 * 20000);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    t_reset();
    t_cmd();
    t_latency();
    t_alert();
    give_verdict();
  end
endmodule
